// [design/mame_exec.sv]
`timescale 1ns/1ps
// four-phase execute for moves and literal multiply
module mame_exec (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [15:0] instr,
   input wire logic instr_valid,
   input wire logic ext_en,
   input wire logic [7:0] fsr2_low,
   input wire logic [7:0] mem_rdata,
   output mame_pkg::mame_mem_t mem_r,
   output logic [7:0] working_r,
   output logic [7:0] bank_select_register_r,
   output logic [7:0] product_high_r,
   output logic [7:0] product_low_r,
   output logic [1:0] phase_r,
   output logic busy_r
);
   import mame_pkg::*;

   typedef enum {MAME_IDLE, MAME_SECOND} mame_state_t;
   mame_state_t state_r, state_nxt;
   logic [7:0] hold_r;
   logic [11:0] src_r;
   logic [11:0] st_addr;
   logic go;
   logic is_move, is_bank, is_lit, is_mul, is_store;
   logic in_second;
   logic dest_ok;
   logic [15:0] product;
   logic [7:0] lit;
   mame_mem_t mem_nxt;

   function automatic logic is_w(input logic [11:0] a);
      return a == WREG_ADDR;
   endfunction

   // opcode decode; a new word is taken only while idle
   assign lit = instr[7:0];
   assign go = instr_valid && state_r == MAME_IDLE;
   assign in_second = state_r == MAME_SECOND;
   // a second word without its prefix cancels the write
   assign dest_ok = in_second && instr_valid &&
      instr[15:12] == OP_MOVE_SECOND;
   assign is_move = go && instr[15:12] == OP_MOVE_FIRST;
   assign is_bank = go && instr[15:8] == OP_BANK_LOAD;
   assign is_lit = go && instr[15:8] == OP_LIT_LOAD;
   assign is_mul = go && instr[15:8] == OP_MUL_LIT;
   assign is_store = go && instr[15:9] == OP_W_STORE;
   assign product = {8'h00, working_r} * {8'h00, lit};

   mame_addr u_addr (
      .f_addr(instr[7:0]),
      .access_bit(instr[8]),
      .ext_en(ext_en),
      .bank(bank_select_register_r[3:0]),
      .fsr2(fsr2_low),
      .full_addr(st_addr)
   );

   // move holds until phase four of its second cycle
   always_comb begin
      state_nxt = state_r;
      if (phase_r == PH_WRITE) begin
         if (is_move) begin
            state_nxt = MAME_SECOND;
         end else if (in_second) begin
            state_nxt = MAME_IDLE;
         end
      end
   end

   // memory strobe; no read at all in the second move cycle
   always_comb begin
      mem_nxt = '0;
      if (phase_r == PH_DECODE && is_move) begin
         mem_nxt.rd = !is_w(instr[11:0]);
         mem_nxt.addr = instr[11:0];
      end else if (phase_r == PH_PROCESS && dest_ok &&
                   !is_w(instr[11:0])) begin
         mem_nxt.wr = 1'b1;
         mem_nxt.addr = instr[11:0];
         mem_nxt.wdata = hold_r;
      end else if (phase_r == PH_PROCESS && is_store) begin
         mem_nxt.wr = 1'b1;
         mem_nxt.addr = st_addr;
         mem_nxt.wdata = working_r;
      end
   end

   // phase counter, move state and registered strobes
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         phase_r <= PH_DECODE;
         state_r <= MAME_IDLE;
         mem_r <= '0;
         busy_r <= 1'b0;
         src_r <= '0;
      end else begin
         phase_r <= phase_r + 2'h1;
         state_r <= state_nxt;
         mem_r <= mem_nxt;
         busy_r <= state_nxt == MAME_SECOND;
         if (phase_r == PH_DECODE && is_move) src_r <= instr[11:0];
      end
   end

   // operand capture and phase four writes; no status flags exist here
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         hold_r <= RESET_BYTE;
         working_r <= RESET_BYTE;
         bank_select_register_r <= RESET_BYTE;
         product_high_r <= RESET_BYTE;
         product_low_r <= RESET_BYTE;
      end else begin
         if (phase_r == PH_READ && mem_r.rd) hold_r <= mem_rdata;
         if (phase_r == PH_READ && is_move && is_w(src_r))
            hold_r <= working_r;
         if (phase_r == PH_WRITE) begin
            if (is_bank) bank_select_register_r <= {4'h0, lit[3:0]};
            if (is_lit) working_r <= lit;
            if (is_mul) begin
               product_high_r <= product[15:8];
               product_low_r <= product[7:0];
            end
            if (dest_ok && is_w(instr[11:0]))
               working_r <= hold_r;
         end
      end
   end

   property p_bank_upper;
      @(posedge mclk) disable iff (sys_rst)
      bank_select_register_r[7:4] == 4'h0;
   endproperty
   a_bank_upper: assert property (p_bank_upper)
      else $error("bank select upper nibble not zero");

   property p_move_two;
      @(posedge mclk) disable iff (sys_rst)
      (phase_r == PH_WRITE && is_move) |=> busy_r [*4] ##1 !busy_r;
   endproperty
   a_move_two: assert property (p_move_two)
      else $error("move did not last two cycles");

   property p_no_second_read;
      @(posedge mclk) disable iff (sys_rst)
      busy_r |-> !mem_r.rd;
   endproperty
   a_no_second_read: assert property (p_no_second_read)
      else $error("dummy read in second move cycle");

   property p_lit;
      @(posedge mclk) disable iff (sys_rst)
      (phase_r == PH_WRITE && is_lit) |=> working_r == $past(lit);
   endproperty
   a_lit: assert property (p_lit)
      else $error("literal not loaded");

   property p_mul;
      @(posedge mclk) disable iff (sys_rst)
      (phase_r == PH_WRITE && is_mul) |=>
         {product_high_r, product_low_r} ==
            {8'h00, $past(working_r)} * {8'h00, $past(lit)}
         && working_r == $past(working_r);
   endproperty
   a_mul: assert property (p_mul)
      else $error("multiply result wrong");

   property p_store;
      @(posedge mclk) disable iff (sys_rst)
      (phase_r == PH_PROCESS && is_store) |=>
         mem_r.wr && mem_r.wdata == working_r && phase_r == PH_WRITE;
   endproperty
   a_store: assert property (p_store)
      else $error("store write missing");

   property p_bank;
      @(posedge mclk) disable iff (sys_rst)
      (phase_r == PH_WRITE && is_bank) |=>
         bank_select_register_r[3:0] == $past(lit[3:0]);
   endproperty
   a_bank: assert property (p_bank)
      else $error("bank select not loaded");

   property p_wr_phase;
      @(posedge mclk) disable iff (sys_rst)
      mem_r.wr |-> phase_r == PH_WRITE;
   endproperty
   a_wr_phase: assert property (p_wr_phase)
      else $error("write outside phase four");

   property p_rd_phase;
      @(posedge mclk) disable iff (sys_rst)
      mem_r.rd |-> phase_r == PH_READ;
   endproperty
   a_rd_phase: assert property (p_rd_phase)
      else $error("read outside phase two");

   // end to end: the byte read is the byte written six phases later
   property p_move_copy;
      @(posedge mclk) disable iff (sys_rst)
      (phase_r == PH_READ && mem_r.rd) |->
         ##6 (!mem_r.wr || mem_r.wdata == $past(mem_rdata, 6));
   endproperty
   a_move_copy: assert property (p_move_copy)
      else $error("moved byte differs from byte read");

   property p_store_bank;
      @(posedge mclk) disable iff (sys_rst)
      (phase_r == PH_PROCESS && is_store && instr[8]) |=>
         mem_r.addr == {$past(bank_select_register_r[3:0]), $past(lit)};
   endproperty
   a_store_bank: assert property (p_store_bank)
      else $error("banked store address wrong");

   property p_indexed;
      @(posedge mclk) disable iff (sys_rst)
      (phase_r == PH_PROCESS && is_store && ext_en && !instr[8]
         && lit <= INDEXED_MAX) |=>
         mem_r.addr == {4'h0, $past(fsr2_low) + $past(lit)};
   endproperty
   a_indexed: assert property (p_indexed)
      else $error("indexed store address wrong");

   // the bank register moves only on its own load
   property p_bank_keep;
      @(posedge mclk) disable iff (sys_rst)
      !(phase_r == PH_WRITE && is_bank) |=>
         $stable(bank_select_register_r);
   endproperty
   a_bank_keep: assert property (p_bank_keep)
      else $error("bank select changed without a load");

   property p_single;
      @(posedge mclk) disable iff (sys_rst)
      (phase_r == PH_WRITE && (is_store || is_lit || is_mul || is_bank))
         |=> !busy_r && phase_r == PH_DECODE;
   endproperty
   a_single: assert property (p_single)
      else $error("one-word instruction held the core");
endmodule

// [design/mame_pkg.sv]
package mame_pkg;
   localparam logic [3:0] OP_MOVE_FIRST = 4'hc;
   localparam logic [3:0] OP_MOVE_SECOND = 4'hf;
   localparam logic [7:0] OP_BANK_LOAD = 8'h01;
   localparam logic [7:0] OP_LIT_LOAD = 8'h0e;
   localparam logic [7:0] OP_MUL_LIT = 8'h0d;
   localparam logic [6:0] OP_W_STORE = 7'h37;
   localparam logic [7:0] INDEXED_MAX = 8'h5f;
   localparam logic [7:0] ACCESS_SPLIT = 8'h60;
   localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
   localparam logic [11:0] WREG_ADDR = 12'hfe8;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [1:0] PH_DECODE = 2'h0;
   localparam logic [1:0] PH_READ = 2'h1;
   localparam logic [1:0] PH_PROCESS = 2'h2;
   localparam logic [1:0] PH_WRITE = 2'h3;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [11:0] addr;
      logic [7:0] wdata;
   } mame_mem_t;
endpackage

// [design/mame_addr.sv]
`timescale 1ns/1ps
// bank-relative address forming for the working store
module mame_addr (
   input wire logic [7:0] f_addr,
   input wire logic access_bit,
   input wire logic ext_en,
   input wire logic [3:0] bank,
   input wire logic [7:0] fsr2,
   output logic [11:0] full_addr
);
   import mame_pkg::*;

   logic indexed;
   logic low_access;
   logic [7:0] idx_low;
   assign indexed = ext_en && !access_bit && (f_addr <= INDEXED_MAX);
   assign low_access = f_addr < ACCESS_SPLIT;
   assign idx_low = fsr2 + f_addr;
   // access bank splits into low ram and the high special registers
   assign full_addr = indexed ? {4'h0, idx_low} :
      access_bit ? {bank, f_addr} :
      low_access ? {4'h0, f_addr} : {ACCESS_HIGH_BANK, f_addr};
endmodule

// [bench/move_and_multiply_execute_bench.sv]
`timescale 1ns/1ps
module move_and_multiply_execute_bench;
   import mame_pkg::*;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic [15:0] instr = 16'h0000;
   logic instr_valid = 1'b0;
   logic ext_en = 1'b0;
   logic ext_nxt = 1'b0;
   logic [7:0] fsr2_low = 8'h10;
   logic [7:0] mem_rdata = 8'h00;
   mame_mem_t mem_r, p2, p4;
   logic [7:0] working_r, bank_sel, prod_h, prod_l;
   logic [1:0] phase_r;
   logic busy_r, b2;
   int miscompares = 0;
   int n_compared = 0;

   always #5 mclk = ~mclk;

   mame_exec i_dut (.mclk(mclk), .sys_rst(sys_rst), .instr(instr),
      .instr_valid(instr_valid), .ext_en(ext_en), .fsr2_low(fsr2_low),
      .mem_rdata(mem_rdata), .mem_r(mem_r), .working_r(working_r),
      .bank_select_register_r(bank_sel), .product_high_r(prod_h),
      .product_low_r(prod_l), .phase_r(phase_r), .busy_r(busy_r));

   task automatic chk(input string what, input logic [15:0] exp,
         input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wrap_up();
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // one instruction cycle; entered just after the edge into phase 4
   task automatic cyc(input logic [15:0] word, input logic [7:0] rd);
      @(posedge mclk);
      instr <= word;
      instr_valid <= 1'b1;
      ext_en <= ext_nxt;
      mem_rdata <= ~rd;
      @(posedge mclk);
      mem_rdata <= rd;
      #1;
      p2 = mem_r;
      b2 = busy_r;
      @(posedge mclk);
      mem_rdata <= ~rd; // read data is gone after its sampling edge
      @(posedge mclk);
      #1;
      p4 = mem_r;
   endtask

   // results of one instruction are looked at after the following one
   task automatic t_lit_mul();
      cyc({OP_LIT_LOAD, 8'he2}, 8'h00);
      cyc({OP_MUL_LIT, 8'hc4}, 8'h00);
      chk("working", 16'h00e2, {8'h0, working_r});
      cyc({OP_LIT_LOAD, 8'hff}, 8'h00);
      chk("product", 16'had08, {prod_h, prod_l});
      chk("working kept", 16'h00e2, {8'h0, working_r});
      cyc({OP_MUL_LIT, 8'hff}, 8'h00);
      cyc({OP_MUL_LIT, 8'h00}, 8'h00);
      chk("product max", 16'hfe01, {prod_h, prod_l});
      cyc(16'h0000, 8'h00);
      chk("zero product", 16'h0000, {prod_h, prod_l});
      chk("working kept", 16'h00ff, {8'h0, working_r});
      $display("done lit_mul");
   endtask

   task automatic t_bank();
      cyc({OP_BANK_LOAD, 8'hff}, 8'h00);
      chk("bank no write", 16'h0, {15'h0, p4.wr});
      cyc({OP_BANK_LOAD, 8'h05}, 8'h00);
      chk("bank high nibble", 16'h000f, {8'h0, bank_sel});
      cyc(16'h0000, 8'h00);
      chk("bank", 16'h0005, {8'h0, bank_sel});
      $display("done bank");
   endtask

   task automatic t_store();
      logic [9:0] sel[6] = '{10'h122, 10'h022, 10'h0a0, 10'h25f,
         10'h260, 10'h3ff};
      logic [11:0] want[6] = '{12'h522, 12'h022, 12'hfa0, 12'h06f,
         12'hf60, 12'h5ff};
      cyc({OP_LIT_LOAD, 8'h4f}, 8'h00);
      for (int i = 0; i < 6; i++) begin
         ext_nxt = sel[i][9];
         cyc({OP_W_STORE, sel[i][8:0]}, 8'h00);
         chk("store addr", {4'h0, want[i]}, {4'h0, p4.addr});
         chk("store data", 16'h014f, {7'h0, p4.wr, p4.wdata});
      end
      ext_nxt = 1'b0;
      $display("done store");
   endtask

   // destinations stay clear of counter and stack bytes
   task automatic t_move();
      cyc({OP_MOVE_FIRST, 12'h123}, 8'h33);
      chk("src read", 16'h1123, {3'h0, p2.rd, p2.addr});
      chk("first no write", 16'h0, {15'h0, p4.wr});
      cyc({OP_MOVE_SECOND, 12'habc}, 8'h55);
      chk("no dummy read", 16'h0001, {14'h0, p2.rd, b2});
      chk("dest write", 16'h1abc, {3'h0, p4.wr, p4.addr});
      chk("moved byte", 16'h0033, {8'h0, p4.wdata});
      cyc({OP_MOVE_FIRST, WREG_ADDR}, 8'h66);
      cyc({OP_MOVE_SECOND, 12'h045}, 8'h00);
      chk("w source", 16'h014f, {7'h0, p4.wr, p4.wdata});
      cyc({OP_MOVE_FIRST, 12'h200}, 8'h99);
      cyc({OP_MOVE_SECOND, WREG_ADDR}, 8'h00);
      chk("w dest no write", 16'h0, {15'h0, p4.wr});
      cyc(16'h0000, 8'h00);
      chk("w dest", 16'h0099, {8'h0, working_r});
      $display("done move");
   endtask

   initial begin
      @(posedge mclk);
      #1;
      chk("reset regs", 16'h0, {working_r | bank_sel, prod_h | prod_l});
      @(posedge mclk);
      sys_rst <= 1'b0;
      // align to the last phase before the first instruction
      for (int i = 0; i < 8; i++) begin
         @(negedge mclk);
         if (phase_r === 2'h3) break;
      end
      chk("phase align", 16'h0003, {14'h0, phase_r});
      // without phase four in sight the scenarios are skipped
      if (phase_r === 2'h3) begin
         t_lit_mul();
         t_bank();
         t_store();
         t_move();
      end
      wrap_up();
   end
endmodule
